// file: core/dlbc_reg8.sv
// Purpose: One 8-bit configuration register with write enable and reset value.
// Assumes: Synchronous active-high reset.
// Notes: Bits outside the mask always hold zero.
`timescale 1ns/1ps
module dlbc_reg8 #(
    parameter logic [7:0] RST_VAL = 8'h00,
    parameter logic [7:0] MASK = 8'hFF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] q
);
    logic [7:0] q_ff;
    logic [7:0] nxt_q;

    always_comb begin
        nxt_q = q_ff;
        if (we) begin
            nxt_q = wdata & MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q_ff <= RST_VAL & MASK;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign q = q_ff;
endmodule : dlbc_reg8

// file: core/dlbc_top.sv
// Purpose: Loop bandwidth configuration registers for the main and secondary phase loops.
// Assumes: Single 100 MHz clock; phase lock status comes from the main loop on the same clock.
// Notes: Read data stand in the cycle after the read strobe only.
`timescale 1ns/1ps
`include "dlbc_defines.svh"

// How it works
// - Secondary field codes 00,01,10 select 18,35,70 Hz; 11 is reserved.
// - Software writes and reads back the secondary bandwidth register.
// - Main locked bandwidth sits in bits [3:0], applied while locked.
// - Main codes 1000..1011 select 0.3, 0.6, 1.2, 2.5 Hz.
// - Main code 1100 selects 4 Hz and 1101 selects 8 Hz.
// - Auto bit chooses locked bandwidth always, or only once lock is achieved.
module dlbc_top
    import dlbc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic phase_locked,
    output logic [1:0] secondary_loop_bw_sel,
    output logic secondary_bw_valid,
    output logic [3:0] main_loop_locked_bw_sel,
    output logic main_use_locked_bw,
    output logic main_bw_valid,
    output logic [3:0] main_bw_step
);

    ////////////////////////////////////////////////////////////////////////////////
    // Decoders.

    // Secondary code to one-hot step.
    function automatic dlbc_sec_bw_t sec_decode(input logic [1:0] code);
        unique case (code)
            2'h0: sec_decode = DLBC_SEC_18HZ;
            2'h1: sec_decode = DLBC_SEC_35HZ;
            2'h2: sec_decode = DLBC_SEC_70HZ;
            default: sec_decode = DLBC_SEC_BAD;
        endcase
    endfunction : sec_decode

    // Main code to step index 0..9 (0.3 Hz .. 70 Hz); 4'hF marks an unused code.
    function automatic logic [3:0] main_decode(input logic [3:0] code);
        unique case (code)
            4'h8: main_decode = 4'h0;
            4'h9: main_decode = 4'h1;
            4'hA: main_decode = 4'h2;
            4'hB: main_decode = 4'h3;
            4'hC: main_decode = 4'h4;
            4'hD: main_decode = 4'h5;
            4'hE: main_decode = 4'h6;
            4'hF: main_decode = 4'h7;
            4'h0: main_decode = 4'h8;
            4'h1: main_decode = 4'h9;
            default: main_decode = 4'hF;
        endcase
    endfunction : main_decode

    // Address match used by both write and read paths.
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    dlbc_req_t req;
    logic [7:0] sec_q;
    logic [7:0] main_q;
    logic [7:0] auto_q;
    logic lock_meta_ff;
    logic lock_sync_ff;

    assign req = '{wr: wr_stb, rd: rd_stb, addr: addr, wdata: wdata};

    dlbc_reg8 #(.RST_VAL(`DLBC_RST_SEC_BW), .MASK(8'h03)) u_sec_reg (
        .clk(clk),
        .rst(rst),
        .we(req.wr && hit(req.addr, `DLBC_OFS_SEC_BW)),
        .wdata(req.wdata),
        .q(sec_q)
    );

    dlbc_reg8 #(.RST_VAL(`DLBC_RST_MAIN_BW), .MASK(8'h0F)) u_main_reg (
        .clk(clk),
        .rst(rst),
        .we(req.wr && hit(req.addr, `DLBC_OFS_MAIN_BW)),
        .wdata(req.wdata),
        .q(main_q)
    );

    dlbc_reg8 #(.RST_VAL(`DLBC_RST_AUTO_SW), .MASK(8'h80)) u_auto_reg (
        .clk(clk),
        .rst(rst),
        .we(req.wr && hit(req.addr, `DLBC_OFS_AUTO_SW)),
        .wdata(req.wdata),
        .q(auto_q)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Lock status synchroniser; the lock signal may come from a slow detector.

    always_ff @(posedge clk) begin
        if (rst) begin
            lock_meta_ff <= 1'b0;
            lock_sync_ff <= 1'b0;
        end else begin
            lock_meta_ff <= phase_locked;
            lock_sync_ff <= lock_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Applied bandwidth and read data.

    dlbc_bw_t bw_ff;
    dlbc_bw_t nxt_bw;
    logic use_locked_ff;
    logic nxt_use_locked;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    dlbc_sec_bw_t sec_oh;
    logic [3:0] main_idx;

    always_comb begin
        sec_oh = sec_decode(sec_q[`DLBC_SEC_BW_MSB:0]);
        main_idx = main_decode(main_q[`DLBC_MAIN_BW_MSB:0]);
        nxt_bw.sec_valid = (sec_oh != DLBC_SEC_BAD);
        unique case (sec_oh)
            DLBC_SEC_18HZ: nxt_bw.sec_step = 2'h0;
            DLBC_SEC_35HZ: nxt_bw.sec_step = 2'h1;
            DLBC_SEC_70HZ: nxt_bw.sec_step = 2'h2;
            default: nxt_bw.sec_step = 2'h3;
        endcase
        nxt_bw.main_valid = (main_idx != 4'hF);
        nxt_bw.main_step = main_idx;
        // Clear auto bit: locked bandwidth always; set: only once locked.
        nxt_use_locked = !auto_q[`DLBC_AUTO_SW_BIT] || lock_sync_ff;
        nxt_rdata = `DLBC_RD_UNMAPPED;
        if (req.rd) begin
            if (hit(req.addr, `DLBC_OFS_SEC_BW)) begin
                nxt_rdata = sec_q;
            end else if (hit(req.addr, `DLBC_OFS_MAIN_BW)) begin
                nxt_rdata = main_q;
            end else if (hit(req.addr, `DLBC_OFS_AUTO_SW)) begin
                nxt_rdata = auto_q;
            end else if (hit(req.addr, `DLBC_OFS_STATUS)) begin
                nxt_rdata = {3'h0, lock_sync_ff, use_locked_ff, bw_ff.main_valid,
                    bw_ff.sec_valid, 1'b0};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bw_ff <= '{sec_valid: 1'b1, sec_step: 2'h0, main_valid: 1'b1, main_step: 4'h5};
            use_locked_ff <= 1'b1;
            rdata_ff <= `DLBC_RD_UNMAPPED;
        end else begin
            bw_ff <= nxt_bw;
            use_locked_ff <= nxt_use_locked;
            rdata_ff <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs, all from flip-flops.

    assign rdata = rdata_ff;
    assign secondary_loop_bw_sel = bw_ff.sec_step;
    assign secondary_bw_valid = bw_ff.sec_valid;
    assign main_loop_locked_bw_sel = bw_ff.main_step;
    assign main_bw_valid = bw_ff.main_valid;
    assign main_bw_step = bw_ff.main_step;
    assign main_use_locked_bw = use_locked_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    sec_decode_a: assert property (@(posedge clk) disable iff (rst)
        (sec_q[1:0] == 2'h1) |=> (secondary_loop_bw_sel == 2'h1 && secondary_bw_valid))
        else $error("Secondary code 01 not applied as 35 Hz step.");

    sec_reserved_a: assert property (@(posedge clk) disable iff (rst)
        (sec_q[1:0] == 2'h3) |=> !secondary_bw_valid)
        else $error("Reserved secondary code shown as valid.");

    sec_readback_a: assert property (@(posedge clk) disable iff (rst)
        (wr_stb && addr == `DLBC_OFS_SEC_BW) ##1 (rd_stb && addr == `DLBC_OFS_SEC_BW && !wr_stb)
        |=> (rdata == {6'h00, $past(wdata[1:0], 2)}))
        else $error("Secondary register read back differs from write.");

    main_write_a: assert property (@(posedge clk) disable iff (rst)
        (wr_stb && addr == 8'h67) |=> (main_q == {4'h0, $past(wdata[3:0])}))
        else $error("Main locked bandwidth field not stored in bits 3:0.");

    main_low_a: assert property (@(posedge clk) disable iff (rst)
        (main_q[3:0] == 4'hB) |=> (main_bw_step == 4'h3 && main_bw_valid))
        else $error("Code 1011 not applied as 2.5 Hz step.");

    main_mid_a: assert property (@(posedge clk) disable iff (rst)
        (main_q[3:0] == 4'hC) |=> (main_bw_step == 4'h4))
        else $error("Code 1100 not applied as 4 Hz step.");

    auto_switch_a: assert property (@(posedge clk) disable iff (rst)
        (auto_q[7] && !lock_sync_ff) |=> !main_use_locked_bw)
        else $error("Locked bandwidth used before lock in automatic mode.");

    always_locked_a: assert property (@(posedge clk) disable iff (rst)
        !auto_q[7] |=> main_use_locked_bw)
        else $error("Locked bandwidth not used while automatic mode is off.");

    main_unused_a: assert property (@(posedge clk) disable iff (rst)
        (main_q[3:0] == 4'h5) |=> !main_bw_valid)
        else $error("Unused main code shown as valid.");

    main_high_a: assert property (@(posedge clk) disable iff (rst)
        (main_q[3:0] == 4'h1) |=> (main_bw_step == 4'h9 && main_bw_valid))
        else $error("Code 0001 not applied as the highest step.");

endmodule : dlbc_top

// file: inc/dlbc_defines.svh
// Purpose: Offsets, field positions, reset values and codes of the loop bandwidth registers.
// Assumes: Register port with 8-bit data and byte addresses.
// Notes: Included by the top design module and the testbench.
`ifndef DLBC_DEFINES_SVH
`define DLBC_DEFINES_SVH

`define DLBC_ADDR_W 8
`define DLBC_OFS_SEC_BW 8'h66
`define DLBC_OFS_MAIN_BW 8'h67
`define DLBC_OFS_AUTO_SW 8'h3B
`define DLBC_OFS_STATUS 8'h6A
`define DLBC_SEC_BW_MSB 1
`define DLBC_MAIN_BW_MSB 3
`define DLBC_AUTO_SW_BIT 7
`define DLBC_RST_SEC_BW 8'h00
`define DLBC_RST_MAIN_BW 8'h0D
`define DLBC_RST_AUTO_SW 8'h00
`define DLBC_RST_SEL 4'h0
`define DLBC_RD_UNMAPPED 8'h00

`endif

// file: inc/dlbc_pkg.sv
// Purpose: Types shared by the loop bandwidth register bank.
// Assumes: Defines header is on the include path.
// Notes: Secondary codes decode to one-hot steps; applied selections are binary indices into a list of steps.
package dlbc_pkg;

    // Secondary loop bandwidth steps.
    typedef enum logic [3:0] {
        DLBC_SEC_18HZ = 4'h1,
        DLBC_SEC_35HZ = 4'h2,
        DLBC_SEC_70HZ = 4'h4,
        DLBC_SEC_BAD = 4'h8
    } dlbc_sec_bw_t;

    // Register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dlbc_req_t;

    // Applied loop bandwidths: step index in hertz order, plus a valid flag.
    typedef struct packed {
        logic sec_valid;
        logic [1:0] sec_step;
        logic main_valid;
        logic [3:0] main_step;
    } dlbc_bw_t;

endpackage : dlbc_pkg

// file: sim/testbench.sv
// Purpose: Self-checking bench for the loop bandwidth register bank.
// Assumes: Register port with one-cycle strobes and read data one cycle later.
// Notes: Expected values are derived here from the documented code tables.
`timescale 1ns/1ps
`include "dlbc_defines.svh"

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin fails++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end

module testbench;
    import dlbc_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr_stb = 1'b0;
    logic rd_stb = 1'b0;
    logic phase_locked = 1'b0;
    logic [7:0] rdata;
    logic [1:0] secondary_loop_bw_sel;
    logic secondary_bw_valid;
    logic [3:0] main_loop_locked_bw_sel;
    logic main_use_locked_bw;
    logic main_bw_valid;
    logic [3:0] main_bw_step;
    logic [7:0] rd_val;
    logic [3:0] exp_step;
    int fails = 0;
    int samples_checked = 0;

    dlbc_top i_dlbc_top (
        .clk(clk),
        .rst(rst),
        .addr(addr),
        .wdata(wdata),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb),
        .rdata(rdata),
        .phase_locked(phase_locked),
        .secondary_loop_bw_sel(secondary_loop_bw_sel),
        .secondary_bw_valid(secondary_bw_valid),
        .main_loop_locked_bw_sel(main_loop_locked_bw_sel),
        .main_use_locked_bw(main_use_locked_bw),
        .main_bw_valid(main_bw_valid),
        .main_bw_step(main_bw_step)
    );

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        if (fails == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask : wr

    // Read data are sampled in the single cycle after the strobe.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        d = rdata;
    endtask : rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        finish_test();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        settle(1);
        `CHK("sec_sel_rst", 2'h0, secondary_loop_bw_sel)
        `CHK("main_step_rst", 4'h5, main_bw_step)
        `CHK("use_locked_rst", 1'b1, main_use_locked_bw)
        rd(`DLBC_OFS_SEC_BW, rd_val);
        `CHK("sec_reg_rst", 8'h00, rd_val)
        settle(0);
        @(posedge clk);
        #1;
        `CHK("rdata_after", 8'h00, rdata)
        rd(`DLBC_OFS_MAIN_BW, rd_val);
        `CHK("main_reg_rst", 8'h0D, rd_val)
        for (int c = 0; c < 4; c++) begin
            wr(`DLBC_OFS_SEC_BW, {6'h3F, c[1:0]});
            rd(`DLBC_OFS_SEC_BW, rd_val);
            `CHK("sec_readback", {6'h00, c[1:0]}, rd_val)
            settle(1);
            `CHK("sec_sel", c[1:0], secondary_loop_bw_sel)
            `CHK("sec_valid", (c != 3), secondary_bw_valid)
        end
        for (int c = 0; c < 16; c++) begin
            exp_step = (c >= 8) ? 4'(c - 8) : ((c < 2) ? 4'(c + 8) : 4'hF);
            wr(`DLBC_OFS_MAIN_BW, {4'hF, c[3:0]});
            rd(`DLBC_OFS_MAIN_BW, rd_val);
            `CHK("main_readback", {4'h0, c[3:0]}, rd_val)
            settle(1);
            `CHK("main_sel", exp_step, main_loop_locked_bw_sel)
            `CHK("main_step", exp_step, main_bw_step)
            `CHK("main_valid", (exp_step != 4'hF), main_bw_valid)
            `CHK("use_locked_always", 1'b1, main_use_locked_bw)
        end
        @(posedge clk);
        wr_stb <= 1'b1;
        addr <= `DLBC_OFS_SEC_BW;
        wdata <= 8'h02;
        @(posedge clk);
        wr_stb <= 1'b0;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1;
        `CHK("sec_back_to_back", 8'h02, rdata)
        wr(8'h10, 8'hA5);
        rd(8'h10, rd_val);
        `CHK("unmapped_read", 8'h00, rd_val)
        wr(`DLBC_OFS_AUTO_SW, 8'h80);
        rd(`DLBC_OFS_AUTO_SW, rd_val);
        `CHK("auto_readback", 8'h80, rd_val)
        settle(3);
        `CHK("auto_unlocked", 1'b0, main_use_locked_bw)
        @(posedge clk);
        phase_locked <= 1'b1;
        settle(1);
        `CHK("auto_lock_early", 1'b0, main_use_locked_bw)
        settle(2);
        `CHK("auto_locked", 1'b1, main_use_locked_bw)
        @(posedge clk);
        phase_locked <= 1'b0;
        settle(4);
        `CHK("auto_lock_lost", 1'b0, main_use_locked_bw)
        wr(`DLBC_OFS_AUTO_SW, 8'h00);
        settle(2);
        `CHK("always_locked", 1'b1, main_use_locked_bw)
        finish_test();
    end
endmodule : testbench
